// *** design/clk_switch_pkg.sv ***
// Notes on behaviour
// - switching and monitor only when cfg bit low
// - switching off: current source from initial cfg
// - switching off: request bit reads zero
// - equal sources: clear request, abort
// - valid switch clears lock and fail flags
// - start oscillator, wait startup timer or lock
// - count ten new-clock cycles before changeover
// - done: clear request, copy requested to current
// - old oscillator off, with listed exceptions
// - core keeps running during switch
// - primary submode fixed by configuration
// - monitor on: low-power rc runs except sleep
// - failure: trap event, fall back to fast rc
// - fallback keeps pll when pll was used
// - sleep stops clock, monitor, clocked peripherals
// - watchdog cleared; low-power rc stays if enabled
// - wake on interrupt, reset or watchdog timeout
// - sleep wake keeps same clock source
// - idle: core stops, watchdog cleared, clock runs
// - idle wake resumes after two to four cycles
// - source field encodings
// - byte write only right after unlock
package clk_switch_pkg;
    // ------------------------------------------------------------
    // register map (word addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_UNLOCK = 4'h1;
    localparam logic [3:0] ADDR_POWER_SAVE_INSTRUCTION = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam logic [7:0] UNLOCK_KEY3 = 8'h9A;
    localparam logic [7:0] UNLOCK_KEY4 = 8'hB3;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CUR_LSB = 12;
    localparam int REQ_LSB = 8;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SEC_EN_BIT = 1;
    localparam int SW_REQ_BIT = 0;
    // ------------------------------------------------------------
    // source encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_FRC = 3'b000,
        SRC_FRC_PLL = 3'b001,
        SRC_PRI = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_SEC = 3'b100,
        SRC_LOW_POWER_RC_OSC = 3'b101,
        SRC_FRC_DIV16 = 3'b110
    } src_t;
    localparam int NSRC = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [3:0] NEW_CLK_CYCLES = 4'hA;
    localparam logic [2:0] IDLE_WAKE_CYCLES = 3'h3;
    localparam logic [3:0] STARTUP_WAIT_MAX = 4'hF;
    localparam logic [1:0] POWER_SAVE_INSTRUCTION_SLEEP = 2'h1;
    localparam logic [1:0] POWER_SAVE_INSTRUCTION_IDLE = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_COMPARE = 3'b001,
        ST_START = 3'b010,
        ST_COUNT = 3'b011,
        ST_HANDOVER = 3'b100
    } sw_state_t;
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_SLEEP = 2'b01,
        PM_IDLE = 2'b10,
        PM_WAKE = 2'b11
    } pm_state_t;
endpackage

// *** design/clock_switch_failsafe_power_save.sv ***
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module clock_switch_failsafe_power_save (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [15:0] writedata,
    input wire logic [1:0] byteenable,
    output logic [15:0] readdata,
    output logic waitrequest,
    // configuration straps
    input wire logic switch_monitor_cfg_bit,
    input wire logic [2:0] initial_source_cfg,
    input wire logic [1:0] primary_submode_cfg,
    input wire logic watchdog_enable,
    // oscillator status pins (asynchronous)
    input wire logic [clk_switch_pkg::NSRC-1:0] osc_ready_pin,
    input wire logic pll_lock_pin,
    input wire logic osc_fail_pin,
    input wire logic [clk_switch_pkg::NSRC-1:0] new_clk_tick_pin,
    // wake sources (asynchronous)
    input wire logic irq_wake_pin,
    input wire logic watchdog_timeout_pin,
    // oscillator and clock control
    output logic [clk_switch_pkg::NSRC-1:0] osc_enable,
    output logic [2:0] sys_clk_select,
    output logic [1:0] primary_submode,
    output logic pll_in_use,
    output logic sys_clk_gate,
    output logic low_power_rc_osc_enable,
    output logic monitor_active,
    output logic clock_fail_trap,
    output logic watchdog_clear,
    output logic core_run,
    output logic periph_clk_enable
);
    import clk_switch_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 2 * NSRC + 5;
    logic [SW-1:0] sync1_reg, sync2_reg;
    wire [SW-1:0] raw_in = {osc_ready_pin, new_clk_tick_pin, pll_lock_pin,
        osc_fail_pin, irq_wake_pin, watchdog_timeout_pin, 1'b0};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire [NSRC-1:0] osc_ready = sync2_reg[SW-1 -: NSRC];
    wire [NSRC-1:0] tick_s = sync2_reg[NSRC+4 -: NSRC];
    wire lock_s = sync2_reg[4];
    wire fail_s = sync2_reg[3];
    wire irq_s = sync2_reg[2];
    wire wdt_to_s = sync2_reg[1];
    logic [NSRC-1:0] tick_d_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tick_d_reg <= '0;
        else tick_d_reg <= tick_s;
    end
    wire [NSRC-1:0] tick_rise = tick_s & ~tick_d_reg;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] cur_reg, cur_next, req_reg, req_next;
    logic sw_req_reg, sw_req_next, lock_reg, lock_next;
    logic fail_reg, fail_next, sec_en_reg, sec_en_next;
    logic [1:0] unlock_reg, unlock_next;
    logic [1:0] stage_reg, stage_next;
    sw_state_t sw_reg, sw_next;
    pm_state_t pm_reg, pm_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [2:0] wake_cnt_reg, wake_cnt_next;
    logic [2:0] old_reg, old_next;
    logic old_on_reg, old_on_next;
    logic trap_reg, trap_next, wdt_clr_reg, wdt_clr_next;
    logic sw_en_reg, strap_ok_reg;
    logic [1:0] submode_reg;
    logic wdt_en_reg;
    logic [2:0] init_reg;

    // straps caught after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_ok_reg <= 1'b0;
            sw_en_reg <= 1'b0;
            submode_reg <= 2'h0;
            wdt_en_reg <= 1'b0;
            init_reg <= 3'h0;
        end else if (!strap_ok_reg) begin
            strap_ok_reg <= 1'b1;
            sw_en_reg <= ~switch_monitor_cfg_bit;
            submode_reg <= primary_submode_cfg;
            wdt_en_reg <= watchdog_enable;
            init_reg <= initial_source_cfg;
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_ctrl = write && address == ADDR_CTRL;
    wire wr_unlock = write && address == ADDR_UNLOCK;
    wire wr_power_save_instruction = write && address == ADDR_POWER_SAVE_INSTRUCTION && pm_reg == PM_RUN;
    wire [7:0] wlo = writedata[7:0];
    wire unlocked = unlock_reg == 2'h3;
    wire wr_hi = wr_ctrl && byteenable[1] && unlocked && stage_reg == 2'h1;
    wire wr_lo = wr_ctrl && byteenable[0] && unlocked && stage_reg == 2'h2;
    wire sleeping = pm_reg == PM_SLEEP;
    wire wake_ev = irq_s || wdt_to_s;
    wire monitor_on = sw_en_reg && !sleeping;
    wire pll_src = cur_reg == SRC_FRC_PLL || cur_reg == SRC_PRI_PLL;
    wire fail_ev = monitor_on && fail_s && sw_reg == ST_IDLE && !fail_reg;
    wire tgt_pll = req_reg == SRC_FRC_PLL || req_reg == SRC_PRI_PLL;
    wire [15:0] ctrl_rd = {1'b0, cur_reg, 1'b0, req_reg, 2'b00, lock_reg,
        1'b0, fail_reg, 1'b0, sec_en_reg, sw_req_reg};
    wire [15:0] stat_rd = {11'h000, pm_reg, sw_reg};

    // one wait state per read, so data stand at the accepting edge
    logic rd_done_reg;
    wire rd_load = read && !rd_done_reg;
    assign waitrequest = rd_load;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 16'h0000;
            rd_done_reg <= 1'b0;
        end else begin
            rd_done_reg <= rd_load;
            if (rd_load) begin
                case (address)
                    ADDR_CTRL: readdata <= ctrl_rd;
                    ADDR_STATUS: readdata <= stat_rd;
                    default: readdata <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // unlock sequence: key1,key2 opens high byte; key3,key4 low byte
    // ------------------------------------------------------------
    always_comb begin
        unlock_next = 2'h0; // any other access closes the window
        stage_next = 2'h0;
        if (wr_unlock && unlock_reg == 2'h0 && wlo == UNLOCK_KEY1) begin
            unlock_next = 2'h1;
            stage_next = 2'h1;
        end else if (wr_unlock && unlock_reg == 2'h0 &&
                     wlo == UNLOCK_KEY3) begin
            unlock_next = 2'h1;
            stage_next = 2'h2;
        end else if (wr_unlock && unlock_reg == 2'h1 &&
                     wlo == (stage_reg == 2'h1 ? UNLOCK_KEY2 : UNLOCK_KEY4)) begin
            unlock_next = 2'h3;
            stage_next = stage_reg;
        end
    end

    // ------------------------------------------------------------
    // switch sequencer
    // ------------------------------------------------------------
    always_comb begin
        sw_next = sw_reg;
        cur_next = cur_reg;
        req_next = wr_hi ? writedata[10:8] : req_reg;
        sec_en_next = wr_lo ? writedata[SEC_EN_BIT] : sec_en_reg;
        sw_req_next = sw_req_reg;
        lock_next = lock_s;
        fail_next = fail_reg;
        cnt_next = cnt_reg;
        old_next = old_reg;
        old_on_next = 1'b0;
        trap_next = 1'b0;
        if (!sw_en_reg) begin
            cur_next = init_reg;
            sw_req_next = 1'b0;
        end else if (fail_ev) begin
            trap_next = 1'b1;
            fail_next = 1'b1;
            cur_next = pll_src ? SRC_FRC_PLL : SRC_FRC;
            sw_next = ST_IDLE;
        end else begin
            case (sw_reg)
                ST_IDLE: if (sw_req_reg && !sleeping) sw_next = ST_COMPARE;
                ST_COMPARE: begin
                    if (cur_reg == req_reg) begin
                        sw_req_next = 1'b0;
                        sw_next = ST_IDLE;
                    end else begin
                        lock_next = 1'b0;
                        fail_next = 1'b0;
                        cnt_next = 4'h0;
                        sw_next = ST_START;
                    end
                end
                ST_START: begin
                    lock_next = tgt_pll ? lock_s : 1'b0;
                    if (osc_ready[req_reg] && (!tgt_pll || lock_s)) begin
                        cnt_next = 4'h0;
                        sw_next = ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (tick_rise[req_reg])
                        cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == NEW_CLK_CYCLES)
                        sw_next = ST_HANDOVER;
                end
                ST_HANDOVER: begin
                    old_next = cur_reg;
                    old_on_next = 1'b1;
                    cur_next = req_reg;
                    sw_req_next = 1'b0;
                    sw_next = ST_IDLE;
                end
                default: sw_next = ST_IDLE;
            endcase
            // a request written as hardware clears it wins
            if (wr_lo && writedata[SW_REQ_BIT])
                sw_req_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power-save modes
    // ------------------------------------------------------------
    always_comb begin
        pm_next = pm_reg;
        wake_cnt_next = wake_cnt_reg;
        wdt_clr_next = 1'b0;
        case (pm_reg)
            PM_RUN: if (wr_power_save_instruction) begin
                wdt_clr_next = wdt_en_reg;
                if (writedata[1:0] == POWER_SAVE_INSTRUCTION_SLEEP) pm_next = PM_SLEEP;
                else if (writedata[1:0] == POWER_SAVE_INSTRUCTION_IDLE) pm_next = PM_IDLE;
            end
            PM_SLEEP, PM_IDLE: if (wake_ev) begin
                wake_cnt_next = 3'h0;
                pm_next = PM_WAKE;
            end
            PM_WAKE: begin
                wake_cnt_next = wake_cnt_reg + 3'h1;
                if (wake_cnt_reg == IDLE_WAKE_CYCLES - 3'h1)
                    pm_next = PM_RUN;
            end
            default: pm_next = PM_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_reg <= ST_IDLE;
            pm_reg <= PM_RUN;
            cur_reg <= SRC_FRC;
            req_reg <= SRC_FRC;
            sw_req_reg <= 1'b0;
            lock_reg <= 1'b0;
            fail_reg <= 1'b0;
            sec_en_reg <= 1'b0;
            unlock_reg <= 2'h0;
            stage_reg <= 2'h0;
            cnt_reg <= 4'h0;
            wake_cnt_reg <= 3'h0;
            old_reg <= SRC_FRC;
            old_on_reg <= 1'b0;
            trap_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
        end else begin
            sw_reg <= sw_next;
            pm_reg <= pm_next;
            cur_reg <= cur_next;
            req_reg <= req_next;
            sw_req_reg <= sw_req_next;
            lock_reg <= lock_next;
            fail_reg <= fail_next;
            sec_en_reg <= sec_en_next;
            unlock_reg <= unlock_next;
            stage_reg <= stage_next;
            cnt_reg <= cnt_next;
            wake_cnt_reg <= wake_cnt_next;
            old_reg <= old_next;
            old_on_reg <= old_on_next;
            trap_reg <= trap_next;
            wdt_clr_reg <= wdt_clr_next;
        end
    end

    // ------------------------------------------------------------
    // oscillator enables and clock outputs
    // ------------------------------------------------------------
    function automatic logic [NSRC-1:0] osc_of(input logic [2:0] s);
        logic [NSRC-1:0] m;
        m = '0;
        case (s)
            SRC_FRC, SRC_FRC_PLL, SRC_FRC_DIV16: m[SRC_FRC] = 1'b1;
            SRC_PRI, SRC_PRI_PLL: m[SRC_PRI] = 1'b1;
            SRC_SEC: m[SRC_SEC] = 1'b1;
            SRC_LOW_POWER_RC_OSC: m[SRC_LOW_POWER_RC_OSC] = 1'b1;
            default: m = '0;
        endcase
        return m;
    endfunction

    wire low_power_rc_osc_keep = (wdt_en_reg || monitor_on);
    wire [NSRC-1:0] want = (sleeping ? '0 : osc_of(cur_reg))
        | (sw_reg != ST_IDLE && !sleeping ? osc_of(req_reg) : '0)
        | (sec_en_reg ? osc_of(SRC_SEC) : '0)
        | (low_power_rc_osc_keep ? osc_of(SRC_LOW_POWER_RC_OSC) : '0);
    // old source dropped at handover; one-cycle hold lets the mux settle
    wire [NSRC-1:0] hold_old = old_on_reg ? osc_of(old_reg) : '0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_enable <= '0;
            sys_clk_select <= SRC_FRC;
            pll_in_use <= 1'b0;
            low_power_rc_osc_enable <= 1'b0;
            sys_clk_gate <= 1'b0;
        end else begin
            osc_enable <= want | hold_old;
            // select follows cur_reg; both clocks run at handover, but not when a failure falls back to fast rc
            sys_clk_select <= cur_reg;
            pll_in_use <= pll_src;
            low_power_rc_osc_enable <= want[SRC_LOW_POWER_RC_OSC] | low_power_rc_osc_keep;
            sys_clk_gate <= !sleeping && strap_ok_reg;
        end
    end

    assign primary_submode = submode_reg;
    assign monitor_active = monitor_on;
    assign clock_fail_trap = trap_reg;
    assign watchdog_clear = wdt_clr_reg;
    // core runs through switches, stops in sleep and idle
    assign core_run = pm_reg == PM_RUN;
    assign periph_clk_enable = !sleeping;
endmodule

// *** sim/clk_switch_monitor.sv ***
`timescale 1ns/1ps
module clk_switch_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // straps and wake
    input wire logic switch_monitor_cfg_bit,
    input wire logic [2:0] initial_source_cfg,
    input wire logic [1:0] primary_submode_cfg,
    input wire logic watchdog_enable,
    input wire logic irq_wake_pin,
    // clock control
    input wire logic [2:0] sys_clk_select,
    input wire logic [1:0] primary_submode,
    input wire logic pll_in_use,
    input wire logic sys_clk_gate,
    input wire logic low_power_rc_osc_enable,
    input wire logic monitor_active,
    input wire logic clock_fail_trap,
    input wire logic watchdog_clear,
    input wire logic core_run,
    input wire logic periph_clk_enable
);
    import clk_switch_pkg::*;
    // ----
    // helper
    // ----
    // straps land one edge after release, so hold off a few cycles
    logic [2:0] up_cnt;
    always_ff @(posedge clk or posedge rst)
        if (rst) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    wire settled = (up_cnt > 3'h3);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // properties
    // ----
    property p_pri_mode;
        settled |-> primary_submode == primary_submode_cfg;
    endproperty
    a_pri_mode: assert property (p_pri_mode)
        else $error("primary submode differs from strap");
    property p_no_mon;
        settled && switch_monitor_cfg_bit
            |-> !monitor_active && !clock_fail_trap;
    endproperty
    a_no_mon: assert property (p_no_mon)
        else $error("monitor active while switching disabled");
    property p_cur_cfg;
        settled && switch_monitor_cfg_bit
            |-> sys_clk_select == initial_source_cfg;
    endproperty
    a_cur_cfg: assert property (p_cur_cfg)
        else $error("clock source differs from strap");
    property p_fb_frc;
        clock_fail_trap && !pll_in_use |-> ##[1:3] sys_clk_select == SRC_FRC;
    endproperty
    a_fb_frc: assert property (p_fb_frc)
        else $error("no fallback to fast rc");
    property p_fb_pll;
        clock_fail_trap && pll_in_use |-> ##[1:3] sys_clk_select == SRC_FRC_PLL;
    endproperty
    a_fb_pll: assert property (p_fb_pll)
        else $error("fallback lost the pll");
    property p_sleep_off;
        !periph_clk_enable && !$past(periph_clk_enable)
            |-> !sys_clk_gate && !monitor_active;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("clock or monitor alive in sleep");
    property p_low_power_rc_osc;
        settled && monitor_active |-> low_power_rc_osc_enable;
    endproperty
    a_low_power_rc_osc: assert property (p_low_power_rc_osc)
        else $error("low-power rc off with monitor on");
    property p_wdt_clr;
        watchdog_clear |-> ##[0:1] !core_run;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr)
        else $error("watchdog cleared outside power save");
    property p_wdt_req;
        $fell(core_run) && watchdog_enable
            |-> watchdog_clear || $past(watchdog_clear);
    endproperty
    a_wdt_req: assert property (p_wdt_req)
        else $error("watchdog not cleared on power save");
    property p_wake;
        !core_run && irq_wake_pin |-> ##[1:10] core_run;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on interrupt");
    property p_idle_min;
        $rose(core_run) |-> !$past(core_run, 2);
    endproperty
    a_idle_min: assert property (p_idle_min)
        else $error("core resumed too early");
    c_trap: cover property (clock_fail_trap);
    c_sleep: cover property (!periph_clk_enable);
    c_idle: cover property (!core_run && periph_clk_enable);
endmodule

// *** sim/osc_partner.sv ***
`timescale 1ns/1ps
module osc_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench and design controls
    input wire logic slow,
    input wire logic fail_cmd,
    input wire logic [clk_switch_pkg::NSRC-1:0] osc_enable,
    // oscillator status
    output logic [clk_switch_pkg::NSRC-1:0] osc_ready_pin,
    output logic pll_lock_pin,
    output logic osc_fail_pin,
    output logic [clk_switch_pkg::NSRC-1:0] new_clk_tick_pin
);
    import clk_switch_pkg::*;
    // ----
    // oscillators
    // ----
    // all fast rc modes share oscillator bit 0
    localparam int OSC_OF [NSRC] = '{0, 0, 2, 2, 4, 5, 0};
    int warm [NSRC];
    always @(posedge clk or posedge rst) begin
        for (int i = 0; i < NSRC; i++) begin
            if (rst || !osc_enable[OSC_OF[i]]) begin
                warm[i] <= 0;
                osc_ready_pin[i] <= 1'b0;
                new_clk_tick_pin[i] <= 1'b0;
            end else begin
                warm[i] <= warm[i] + 1;
                osc_ready_pin[i] <= (warm[i] >= (slow ? 12 : 1));
                // a stopped clock holds still, no stray ticks
                new_clk_tick_pin[i] <= osc_ready_pin[i] & ~new_clk_tick_pin[i];
            end
        end
    end
    assign pll_lock_pin = osc_ready_pin[SRC_PRI_PLL]
        | osc_ready_pin[SRC_FRC_PLL];
    assign osc_fail_pin = fail_cmd;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import clk_switch_pkg::*;
    // ----
    // signals
    // ----
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [15:0] writedata = 16'h0000, readdata;
    logic [1:0] byteenable = 2'h0, primary_submode_cfg = 2'h0, primary_submode;
    logic switch_monitor_cfg_bit = 1'b1, watchdog_enable = 1'b1;
    logic [2:0] initial_source_cfg = 3'h0, sys_clk_select, cur_m, req_m;
    logic irq_wake_pin = 1'b0, watchdog_timeout_pin = 1'b0;
    logic slow = 1'b0, fail_cmd = 1'b0, waitrequest, pll_lock_pin;
    logic osc_fail_pin, pll_in_use, sys_clk_gate, low_power_rc_osc_enable, monitor_active;
    logic clock_fail_trap, watchdog_clear, core_run, periph_clk_enable;
    logic [NSRC-1:0] osc_ready_pin, new_clk_tick_pin, osc_enable;
    int num_errors = 0, checks_done = 0, seed;
    src_t seq [9] = '{SRC_PRI, SRC_PRI_PLL, SRC_FRC, SRC_FRC_PLL, SRC_FRC,
                      SRC_SEC, SRC_LOW_POWER_RC_OSC, SRC_FRC_DIV16, SRC_PRI_PLL};
    always #25 clk = ~clk;
    clock_switch_failsafe_power_save uut (.clk, .rst, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest,
        .switch_monitor_cfg_bit, .initial_source_cfg, .primary_submode_cfg,
        .watchdog_enable, .osc_ready_pin, .pll_lock_pin, .osc_fail_pin,
        .new_clk_tick_pin, .irq_wake_pin, .watchdog_timeout_pin, .osc_enable,
        .sys_clk_select, .primary_submode, .pll_in_use, .sys_clk_gate,
        .low_power_rc_osc_enable, .monitor_active, .clock_fail_trap, .watchdog_clear,
        .core_run, .periph_clk_enable);
    osc_partner partner (.clk, .rst, .slow, .fail_cmd, .osc_enable,
        .osc_ready_pin, .pll_lock_pin, .osc_fail_pin, .new_clk_tick_pin);
    // ----
    // bus and check tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    function automatic logic [15:0] exp_ctrl(input logic f);
        return {1'b0, cur_m, 1'b0, req_m, 4'h0, f, 3'h0};
    endfunction
    function automatic int osc_of(input logic [2:0] s);
        return (s == 3'h2 || s == 3'h3) ? 2 :
            (s == 3'h4 || s == 3'h5) ? s : 0;
    endfunction
    // holds the request until waitrequest is seen low; no release here
    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
    endtask
    task automatic rel;
        write <= 1'b0;
        @(posedge clk);
    endtask
    // read data taken at the edge that sees waitrequest low
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        address <= a;
        write <= 1'b0;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sw(input logic [2:0] s);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY1}, 2'h1);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY2}, 2'h1);
        wr(ADDR_CTRL, {5'h00, s, 8'h00}, 2'h2);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY3}, 2'h1);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY4}, 2'h1);
        wr(ADDR_CTRL, 16'h0001, 2'h1);
        rel;
        req_m = s;
    endtask
    task automatic settle(output logic [15:0] d);
        int n;
        n = 0;
        do begin
            rd(ADDR_CTRL, d);
            n++;
        end while (d[SW_REQ_BIT] !== 1'b0 && n < 200);
    endtask
    task automatic do_reset(input logic cfg, input logic [2:0] init);
        rst <= 1'b1;
        switch_monitor_cfg_bit <= cfg;
        initial_source_cfg <= init;
        primary_submode_cfg <= 2'($random(seed));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        cur_m = init;
    endtask
    task automatic fail_case(input logic [2:0] fb);
        logic [15:0] dd;
        int n;
        n = 0;
        fail_cmd <= 1'b1;
        while (clock_fail_trap !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        fail_cmd <= 1'b0;
        cur_m = fb;
        rd(ADDR_CTRL, dd);
        chk(dd & 16'h70DF, exp_ctrl(1'b1) & 16'h70DF);
    endtask
    task automatic close_out;
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        #(50 * 20000);
        num_errors++;
        close_out;
    end
    initial begin
        logic [15:0] d;
        logic [2:0] old;
        int n;
        seed = 39188;
        do_reset(1'b1, 3'({$random(seed)} % 7));
        sw(SRC_PRI);
        settle(d);
        chk(d & 16'h7001, {1'b0, cur_m, 12'h000});
        do_reset(1'b0, SRC_FRC);
        sw(SRC_FRC);
        settle(d);
        chk(d & 16'hFFDF, exp_ctrl(1'b0));
        wr(ADDR_CTRL, 16'h0200, 2'h2);
        rel;
        rd(ADDR_CTRL, d);
        chk(d & 16'hFFDF, exp_ctrl(1'b0));
        foreach (seq[i]) begin
            slow <= 1'($random(seed));
            old = cur_m;
            sw(seq[i]);
            settle(d);
            cur_m = seq[i];
            chk(d & 16'hFFDF, exp_ctrl(1'b0));
            chk({13'h0000, sys_clk_select}, {13'h0000, cur_m});
            if (osc_of(old) != osc_of(cur_m))
                chk({15'h0, osc_enable[osc_of(old)]},
                    {15'h0, osc_of(old) == 5});
        end
        fail_case(SRC_FRC_PLL);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY3}, 2'h1);
        wr(ADDR_UNLOCK, {8'h00, UNLOCK_KEY4}, 2'h1);
        wr(ADDR_CTRL, 16'h0002, 2'h1);
        rel;
        repeat (2) @(posedge clk);
        chk({15'h0, osc_enable[SRC_SEC]}, 16'h0001);
        sw(SRC_PRI);
        settle(d);
        cur_m = SRC_PRI;
        chk(d & 16'hFFDF, exp_ctrl(1'b0));
        fail_case(SRC_FRC);
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_POWER_SAVE_INSTRUCTION, {14'h0000, m ? POWER_SAVE_INSTRUCTION_IDLE : POWER_SAVE_INSTRUCTION_SLEEP}, 2'h1);
            rel;
            repeat (3) @(posedge clk);
            chk({13'h0, core_run, periph_clk_enable, sys_clk_gate},
                m ? 16'h0003 : 16'h0000);
            irq_wake_pin <= (m == 0);
            watchdog_timeout_pin <= (m == 1);
            n = 0;
            while (core_run !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
            irq_wake_pin <= 1'b0;
            watchdog_timeout_pin <= 1'b0;
            chk({15'h0, core_run}, 16'h0001);
            rd(ADDR_CTRL, d);
            chk(d & 16'h7000, {1'b0, cur_m, 12'h000});
        end
        close_out;
    end
endmodule

bind clock_switch_failsafe_power_save clk_switch_monitor mon (
    .clk, .rst, .switch_monitor_cfg_bit, .initial_source_cfg,
    .primary_submode_cfg, .watchdog_enable, .irq_wake_pin, .sys_clk_select,
    .primary_submode, .pll_in_use, .sys_clk_gate, .low_power_rc_osc_enable,
    .monitor_active, .clock_fail_trap, .watchdog_clear, .core_run,
    .periph_clk_enable);
